//--- sqw_cfg.svh
// Behaviour
// - The controller drives the write port select low to ask for a write; the device samples it on a true-clock rise and starts a write when low.
// - The write port select is looked at only on the true-clock rise, never on the complementary-clock rise.
// - A write port select sampled high deselects the port and every data input bit is ignored.
// - The controller presents nibble or byte selects with each word and the device samples them on both clock rises.
// - In the 8-bit mode the nibble selects decide which nibble of the current word is stored.
// - The first nibble select gates data bits 3:0 and the second gates bits 7:4.
// - Each nibble select is sampled on the same edge as the word it qualifies, so every word has its own mask.
// - A nibble select sampled high drops that nibble and the stored nibble stays as it was.
// - In the 9, 18 and 36-bit modes the byte selects choose which 9-bit lanes of the word are stored.
// - Byte select 0 gates bits 8:0, 1 gates 17:9, 2 gates 26:18 and 3 gates 35:27; the 9-bit mode uses select 0 only.
// - Each byte select is sampled on the same edge as the word it masks.
// - A byte select sampled high drops that lane and the stored lane keeps its old contents.
// - During writes the controller presents data words and the device samples them on both clock rises.
// - While the write port is deselected the address inputs are ignored for writes.
`ifndef SQW_CFG_SVH
`define SQW_CFG_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define SQW_DATA_W 36
`define SQW_ADDR_W 4
`define SQW_FIFO_DEPTH 8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SQW_OFF_CTRL 8'h00
`define SQW_OFF_STATUS 8'h04
`define SQW_OFF_RD_INDEX 8'h08
`define SQW_OFF_RDATA_LO 8'h0C
`define SQW_OFF_RDATA_HI 8'h10

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SQW_CTRL_EN_BIT 0
`define SQW_CTRL_HOLD_BIT 1
`define SQW_CTRL_MODE_LSB 2
`define SQW_CTRL_RESET 4'hD
`define SQW_ST_EMPTY_BIT 0
`define SQW_ST_FULL_BIT 1
`define SQW_ST_OVF_BIT 2
`define SQW_ST_BUSY_BIT 3
`define SQW_ST_LEVEL_LSB 4
`define SQW_ST_COUNT_LSB 8

`endif

//--- sqw_pkg.sv
package sqw_pkg;

  typedef enum logic [1:0] {
    SQW_X8 = 2'b00,
    SQW_X9 = 2'b01,
    SQW_X18 = 2'b10,
    SQW_X36 = 2'b11
  } sqw_width_t;

  typedef enum logic [1:0] {
    SQW_IDLE = 2'b00,
    SQW_WORD1 = 2'b01
  } sqw_state_t;

endpackage : sqw_pkg

//--- sqw_fifo.sv
`timescale 1ns/1ps
module sqw_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0] store [DEPTH];
  logic [W-1:0] next_store [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] next_level;
  logic push, pop;

  assign in_ready = (level != CW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_store = store;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level = level;
    if (push) begin
      next_store[wr_ptr] = in_data;
      next_wr_ptr = (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_level = level + 1'b1;
    end else if (pop && !push) begin
      next_level = level - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else if (ce) begin
      store <= next_store;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

endmodule : sqw_fifo

//--- sqw_write_port.sv
`timescale 1ns/1ps
`include "sqw_cfg.svh"
module sqw_write_port #(
  parameter int AW = `SQW_ADDR_W,
  parameter int FIFO_DEPTH = `SQW_FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Write port pins
  input wire logic k_clk_in,
  input wire logic k_clk_n_in,
  input wire logic write_port_select_n,
  input wire logic [1:0] nibble_write_select_n,
  input wire logic [3:0] byte_write_select_n,
  input wire logic [`SQW_DATA_W-1:0] data_in,
  input wire logic [AW-1:0] addr_in,
  // Back-pressure
  output logic write_ready
);
  localparam int DW = `SQW_DATA_W;
  localparam int SW = AW + DW + 9;
  localparam int RW = AW + 4 * DW;
  localparam int WORDS = 2 ** (AW + 1);
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SW-1:0] pin_s1, pin_s2, next_pin_s1, next_pin_s2;
  logic k_s3, kn_s3, next_k_s3, next_kn_s3;
  logic k_rise, kn_rise, wps_n_s;
  logic [1:0] nws_s;
  logic [3:0] bws_s;
  logic [DW-1:0] d_s;
  logic [AW-1:0] a_s;

  always_comb begin
    next_pin_s1 = {addr_in, data_in, byte_write_select_n,
                   nibble_write_select_n, write_port_select_n,
                   k_clk_n_in, k_clk_in};
    next_pin_s2 = pin_s1;
    next_k_s3 = pin_s2[0];
    next_kn_s3 = pin_s2[1];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      k_s3 <= 1'b0;
      kn_s3 <= 1'b0;
    end else if (ce) begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
      k_s3 <= next_k_s3;
      kn_s3 <= next_kn_s3;
    end
  end

  // All pins share the same two-stage delay, so data stays aligned to
  // the detected clock edges; pin skew must stay below one hclk period.
  assign k_rise = pin_s2[0] && !k_s3;
  assign kn_rise = pin_s2[1] && !kn_s3;
  assign wps_n_s = pin_s2[2];
  assign nws_s = pin_s2[4:3];
  assign bws_s = pin_s2[8:5];
  assign d_s = pin_s2[9 +: DW];
  assign a_s = pin_s2[9 + DW +: AW];

  // ----------------------------------------------------------------
  // Lane enables
  // ----------------------------------------------------------------
  function automatic logic [DW-1:0] lane_en(
    input sqw_pkg::sqw_width_t m,
    input logic [1:0] nws_n,
    input logic [3:0] bws_n
  );
    logic [DW-1:0] en;
    en = '0;
    for (int i = 0; i < DW; i++) begin
      case (m)
        sqw_pkg::SQW_X8: en[i] = (i < 8) && !nws_n[(i / 4) % 2];
        sqw_pkg::SQW_X9: en[i] = (i < 9) && !bws_n[0];
        sqw_pkg::SQW_X18: en[i] = (i < 18) && !bws_n[i / 9];
        sqw_pkg::SQW_X36: en[i] = !bws_n[i / 9];
        default: en[i] = 1'b0;
      endcase
    end
    return en;
  endfunction : lane_en

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  logic [3:0] ctrl, next_ctrl;
  logic ctrl_en, ctrl_hold;
  sqw_pkg::sqw_width_t mode;
  logic [DW-1:0] en_now;

  assign ctrl_en = ctrl[`SQW_CTRL_EN_BIT];
  assign ctrl_hold = ctrl[`SQW_CTRL_HOLD_BIT];
  assign mode = sqw_pkg::sqw_width_t'(ctrl[`SQW_CTRL_MODE_LSB +: 2]);
  // Each word's mask comes from the selects seen at that word's edge
  assign en_now = lane_en(mode, nws_s, bws_s);

  // ----------------------------------------------------------------
  // Burst capture
  // ----------------------------------------------------------------
  sqw_pkg::sqw_state_t state, next_state;
  logic [DW-1:0] w0_data, w0_en, next_w0_data, next_w0_en;
  logic [RW-1:0] pend_rec, next_pend_rec;
  logic pend_valid, next_pend_valid, burst_drop;
  logic fifo_in_ready;

  always_comb begin
    next_state = state;
    next_w0_data = w0_data;
    next_w0_en = w0_en;
    next_pend_rec = pend_rec;
    next_pend_valid = pend_valid && !fifo_in_ready;
    burst_drop = 1'b0;
    case (state)
      sqw_pkg::SQW_IDLE: begin
        // Select high or port disabled: data and selects are not looked at
        if (k_rise && !wps_n_s && ctrl_en) begin
          next_state = sqw_pkg::SQW_WORD1;
          next_w0_data = d_s;
          next_w0_en = en_now;
        end
      end
      sqw_pkg::SQW_WORD1: begin
        if (kn_rise) begin
          next_state = sqw_pkg::SQW_IDLE;
          if (next_pend_valid) begin
            burst_drop = 1'b1;
          end else begin
            // Address taken only inside a selected burst
            next_pend_rec = {a_s, en_now, d_s, w0_en, w0_data};
            next_pend_valid = 1'b1;
          end
        end else if (k_rise) begin
          // Lost complementary edge: drop the half burst
          next_state = sqw_pkg::SQW_IDLE;
        end
      end
      default: next_state = sqw_pkg::SQW_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= sqw_pkg::SQW_IDLE;
      w0_data <= '0;
      w0_en <= '0;
      pend_rec <= '0;
      pend_valid <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      w0_data <= next_w0_data;
      w0_en <= next_w0_en;
      pend_rec <= next_pend_rec;
      pend_valid <= next_pend_valid;
    end
  end

  // ----------------------------------------------------------------
  // Burst FIFO
  // ----------------------------------------------------------------
  logic fifo_out_valid, fifo_out_ready, drain_fire;
  logic [RW-1:0] fifo_out;
  logic [LW-1:0] fifo_level;

  sqw_fifo #(.W(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .in_valid(pend_valid),
    .in_ready(fifo_in_ready),
    .in_data(pend_rec),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  // Software hold stalls the drain so the FIFO really fills
  assign fifo_out_ready = !ctrl_hold;
  assign drain_fire = fifo_out_valid && fifo_out_ready;
  assign write_ready = fifo_in_ready;

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [WORDS];
  logic [DW-1:0] next_mem [WORDS];
  logic [AW:0] idx0, idx1;
  logic [DW-1:0] o_d0, o_en0, o_d1, o_en1;
  logic [7:0] wr_count, next_wr_count;

  assign o_d0 = fifo_out[0 +: DW];
  assign o_en0 = fifo_out[DW +: DW];
  assign o_d1 = fifo_out[2 * DW +: DW];
  assign o_en1 = fifo_out[3 * DW +: DW];
  assign idx0 = {fifo_out[4 * DW +: AW], 1'b0};
  assign idx1 = {fifo_out[4 * DW +: AW], 1'b1};

  always_comb begin
    next_mem = mem;
    next_wr_count = wr_count;
    if (drain_fire) begin
      // Deselected lanes keep what was stored
      next_mem[idx0] = (mem[idx0] & ~o_en0) | (o_d0 & o_en0);
      next_mem[idx1] = (mem[idx1] & ~o_en1) | (o_d1 & o_en1);
      next_wr_count = wr_count + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= '0;
      end
      wr_count <= 8'h00;
    end else if (ce) begin
      mem <= next_mem;
      wr_count <= next_wr_count;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite registers
  // ----------------------------------------------------------------
  logic dp_valid, dp_write, next_dp_valid, next_dp_write;
  logic [7:0] dp_addr, next_dp_addr;
  logic [AW:0] rd_index, next_rd_index;
  logic overflow, next_overflow;
  logic [31:0] next_hrdata, status;
  logic addr_ok, wr_now;

  // Zero wait states; a low enable stalls the bus instead
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_now = dp_valid && dp_write;

  always_comb begin
    status = 32'h0000_0000;
    status[`SQW_ST_EMPTY_BIT] = !fifo_out_valid;
    status[`SQW_ST_FULL_BIT] = !fifo_in_ready;
    status[`SQW_ST_OVF_BIT] = overflow;
    status[`SQW_ST_BUSY_BIT] = (state == sqw_pkg::SQW_WORD1);
    status[`SQW_ST_LEVEL_LSB +: LW] = fifo_level;
    status[`SQW_ST_COUNT_LSB +: 8] = wr_count;
  end

  always_comb begin
    next_dp_valid = addr_ok;
    next_dp_write = hwrite;
    next_dp_addr = haddr[7:0];
    next_ctrl = ctrl;
    next_rd_index = rd_index;
    next_hrdata = hrdata;
    // A drop in the clearing cycle survives the clear
    next_overflow = overflow;
    if (wr_now && dp_addr == `SQW_OFF_STATUS &&
        hwdata[`SQW_ST_OVF_BIT]) begin
      next_overflow = 1'b0;
    end
    if (burst_drop) begin
      next_overflow = 1'b1;
    end
    if (wr_now && dp_addr == `SQW_OFF_CTRL) begin
      next_ctrl = hwdata[3:0];
    end
    if (wr_now && dp_addr == `SQW_OFF_RD_INDEX) begin
      next_rd_index = hwdata[AW:0];
    end
    // Back-to-back write then read of one register returns the old value
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `SQW_OFF_CTRL: next_hrdata = {28'h000_0000, ctrl};
        `SQW_OFF_STATUS: next_hrdata = status;
        `SQW_OFF_RD_INDEX: next_hrdata = 32'(rd_index);
        `SQW_OFF_RDATA_LO: next_hrdata = mem[rd_index][31:0];
        `SQW_OFF_RDATA_HI: next_hrdata = 32'(mem[rd_index][DW-1:32]);
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      ctrl <= `SQW_CTRL_RESET;
      rd_index <= '0;
      overflow <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      ctrl <= next_ctrl;
      rd_index <= next_rd_index;
      overflow <= next_overflow;
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_start_write: assert property (
    ce && state == sqw_pkg::SQW_IDLE && k_rise && !wps_n_s && ctrl_en
    |=> state == sqw_pkg::SQW_WORD1)
    else $error("Selected true-clock edge did not start a write");

  a_k_edge_only: assert property (
    ce && state == sqw_pkg::SQW_IDLE && kn_rise && !k_rise
    |=> state == sqw_pkg::SQW_IDLE)
    else $error("Complementary edge started a write");

  a_desel_ignore: assert property (
    state == sqw_pkg::SQW_IDLE && (wps_n_s || !k_rise || !ctrl_en)
    |=> $stable(w0_data) && $stable(w0_en))
    else $error("Deselected port captured data");

  a_word0_capture: assert property (
    ce && state == sqw_pkg::SQW_IDLE && k_rise && !wps_n_s && ctrl_en
    |=> w0_data == $past(d_s) && w0_en == $past(en_now))
    else $error("First word or its mask not taken at its edge");

  a_nibble_lanes: assert property (
    mode == sqw_pkg::SQW_X8
    |-> en_now[DW-1:8] == '0 && en_now[3:0] == {4{!nws_s[0]}}
        && en_now[7:4] == {4{!nws_s[1]}})
    else $error("Nibble lane mapping wrong");

  a_byte_lanes: assert property (
    mode == sqw_pkg::SQW_X36
    |-> en_now[8:0] == {9{!bws_s[0]}} && en_now[35:27] == {9{!bws_s[3]}})
    else $error("Byte lane mapping wrong");

  a_byte_nine: assert property (
    mode == sqw_pkg::SQW_X9 |-> en_now[DW-1:9] == '0)
    else $error("Nine-bit mode enabled upper lanes");

  a_mask_keep: assert property (
    ce && drain_fire
    |=> ((mem[$past(idx0)] ^ $past(mem[idx0])) & ~$past(o_en0)) == '0)
    else $error("Masked lane of stored word changed");

  a_addr_ignore: assert property (
    !(state == sqw_pkg::SQW_WORD1 && kn_rise) |=> $stable(pend_rec))
    else $error("Address taken outside a selected burst");

  a_burst_pair: assert property (
    ce && state == sqw_pkg::SQW_WORD1 && kn_rise && !k_rise
    && !(pend_valid && !fifo_in_ready)
    |=> pend_valid && pend_rec[RW-1:4*DW] == $past(a_s)
        && pend_rec[2*DW +: DW] == $past(d_s))
    else $error("Second word of burst not captured");

endmodule : sqw_write_port

//--- sqw_ctrl_model.sv
`timescale 1ns/1ps
module sqw_ctrl_model (
  // Request from the bench
  input wire logic clk,
  input wire logic go,
  input wire logic sel_n,
  input wire logic [3:0] addr,
  input wire logic [35:0] d0,
  input wire logic [35:0] d1,
  input wire logic [5:0] m0,
  input wire logic [5:0] m1,
  input wire logic [2:0] gap,
  output logic busy,
  // Write port pins
  output logic k_clk_in,
  output logic k_clk_n_in,
  output logic write_port_select_n,
  output logic [1:0] nibble_write_select_n,
  output logic [3:0] byte_write_select_n,
  output logic [35:0] data_in,
  output logic [3:0] addr_in
);
  // ----------------------------------------
  // Burst sequencer
  // ----------------------------------------
  // Clocks stand low between bursts
  initial begin
    busy = 1'b0;
    k_clk_in = 1'b0;
    k_clk_n_in = 1'b0;
    write_port_select_n = 1'b1;
    {nibble_write_select_n, byte_write_select_n} = 6'h3F;
    data_in = 36'h0_0000_0000;
    addr_in = 4'h0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      write_port_select_n <= sel_n;
      {nibble_write_select_n, byte_write_select_n} <= m0;
      data_in <= d0;
      hold(3 + gap);
      k_clk_in <= 1'b1;
      hold(4 + gap);
      k_clk_in <= 1'b0;
      // Low here on purpose: only the true edge may count it
      write_port_select_n <= 1'b0;
      {nibble_write_select_n, byte_write_select_n} <= m1;
      data_in <= d1;
      addr_in <= addr;
      hold(3 + gap);
      k_clk_n_in <= 1'b1;
      hold(4 + gap);
      k_clk_n_in <= 1'b0;
      // No pulls on these lines, so show the inverse once released
      write_port_select_n <= 1'b1;
      {nibble_write_select_n, byte_write_select_n} <= ~m1;
      data_in <= ~d1;
      addr_in <= ~addr;
      busy <= 1'b0;
    end
  end
endmodule : sqw_ctrl_model

//--- tb_sram_write_port_select_and_mask.sv
`timescale 1ns/1ps
`include "sqw_cfg.svh"
module tb_sram_write_port_select_and_mask;
  typedef struct {
    logic [31:0] val;
    logic [31:0] msk;
    string nm;
  } sqw_note_t;
  localparam logic [31:0] off_ctrl = 32'(`SQW_OFF_CTRL);
  localparam logic [31:0] off_st = 32'(`SQW_OFF_STATUS);
  localparam logic [31:0] off_idx = 32'(`SQW_OFF_RD_INDEX);
  localparam logic [31:0] off_lo = 32'(`SQW_OFF_RDATA_LO);
  localparam logic [31:0] off_hi = 32'(`SQW_OFF_RDATA_HI);
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, gap;
  logic write_ready, go, sel_n, busy, k_clk_in, k_clk_n_in;
  logic write_port_select_n, rd_dp;
  logic [1:0] nibble_write_select_n, mode;
  logic [3:0] byte_write_select_n, addr_in, baddr;
  logic [35:0] data_in, d0, d1;
  logic [5:0] m0, m1;
  logic [35:0] shadow [32];
  int failures, tests_run, cnt;
  sqw_note_t exp_q[$];
  sqw_note_t nt;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  sqw_write_port #(.AW(4), .FIFO_DEPTH(8)) u_sqw_write_port (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .k_clk_in(k_clk_in),
    .k_clk_n_in(k_clk_n_in), .write_port_select_n(write_port_select_n),
    .nibble_write_select_n(nibble_write_select_n),
    .byte_write_select_n(byte_write_select_n), .data_in(data_in),
    .addr_in(addr_in), .write_ready(write_ready));

  sqw_ctrl_model u_sqw_ctrl_model (
    .clk(hclk), .go(go), .sel_n(sel_n), .addr(baddr), .d0(d0),
    .d1(d1), .m0(m0), .m1(m1), .gap(gap), .busy(busy),
    .k_clk_in(k_clk_in), .k_clk_n_in(k_clk_n_in),
    .write_port_select_n(write_port_select_n),
    .nibble_write_select_n(nibble_write_select_n),
    .byte_write_select_n(byte_write_select_n), .data_in(data_in),
    .addr_in(addr_in));

  // ----------------------------------------
  // Bus tasks and result monitor
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 200);
    rd = hrdata;
  endtask : xfer

  task automatic wr32(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    xfer(1'b1, a, wd, rd);
  endtask : wr32

  task automatic rd32(input logic [31:0] a, input logic [31:0] v,
                      input logic [31:0] m, input string nm,
                      output logic [31:0] rd);
    exp_q.push_back('{v, m, nm});
    xfer(1'b0, a, 32'h0000_0000, rd);
  endtask : rd32

  task automatic chk(input logic [31:0] a, input logic [31:0] v,
                     input logic [31:0] m, input string nm);
    logic [31:0] rd;
    rd32(a, v, m, nm, rd);
  endtask : chk

  task automatic check1(input string nm, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask : check1

  // Polls carry a zero mask and are not compared
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      if (nt.msk !== 32'h0000_0000) begin
        tests_run++;
        if ((hrdata & nt.msk) !== (nt.val & nt.msk)) begin
          failures++;
          $display("ERROR %s expected %h seen %h", nt.nm,
                   nt.val & nt.msk, hrdata & nt.msk);
        end
      end
    end
    if (hreadyout === 1'b1) begin
      rd_dp = hsel === 1'b1 && htrans[1] === 1'b1 && hwrite === 1'b0;
    end
  end

  // ----------------------------------------
  // Write port helpers
  // ----------------------------------------
  function automatic logic [35:0] lanes(input logic [1:0] md,
                                        input logic [5:0] k);
    case (md)
      2'b00: lanes = {28'h0, {4{~k[5]}}, {4{~k[4]}}};
      2'b01: lanes = {27'h0, {9{~k[0]}}};
      2'b10: lanes = {18'h0, {9{~k[1]}}, {9{~k[0]}}};
      default: lanes = {{9{~k[3]}}, {9{~k[2]}}, {9{~k[1]}}, {9{~k[0]}}};
    endcase
  endfunction : lanes

  function automatic logic [35:0] rnd36();
    rnd36 = {4'($urandom), $urandom};
  endfunction : rnd36

  task automatic burst(input logic s, input logic [3:0] a,
                       input logic [35:0] x0, input logic [35:0] x1,
                       input logic [5:0] k0, input logic [5:0] k1);
    int n;
    logic [35:0] l;
    n = 0;
    sel_n <= s;
    baddr <= a;
    d0 <= x0;
    d1 <= x1;
    m0 <= k0;
    m1 <= k1;
    gap <= 3'($urandom_range(0, 3));
    go <= 1'b1;
    do begin
      @(posedge hclk);
      n++;
    end while (busy !== 1'b1 && n < 20);
    go <= 1'b0;
    do begin
      @(posedge hclk);
      n++;
    end while (busy !== 1'b0 && n < 200);
    if (!s) begin
      l = lanes(mode, k0);
      shadow[{a, 1'b0}] = (shadow[{a, 1'b0}] & ~l) | (x0 & l);
      l = lanes(mode, k1);
      shadow[{a, 1'b1}] = (shadow[{a, 1'b1}] & ~l) | (x1 & l);
    end
  endtask : burst

  task automatic wait_cnt(input int c);
    logic [31:0] rd;
    int n;
    n = 0;
    do begin
      rd32(off_st, 32'h0000_0000, 32'h0000_0000, "poll", rd);
      n++;
    end while (rd[15:8] !== 8'(c) && n < 60);
    chk(off_st, 32'(c) << 8, 32'h0000_FF00, "count");
  endtask : wait_cnt

  task automatic rdback(input logic [3:0] a);
    logic [35:0] w;
    logic [35:0] e;
    w = lanes(mode, 6'h00);
    for (int b = 0; b < 2; b++) begin
      e = shadow[{a, b[0]}];
      wr32(off_idx, {27'h0, a, b[0]});
      @(posedge hclk);
      chk(off_lo, e[31:0], w[31:0], "data_lo");
      chk(off_hi, {28'h0, e[35:32]}, {28'h0, w[35:32]}, "data_hi");
    end
  endtask : rdback

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd7e9_448c));
    {hclk, hresetn, hsel, hwrite, go, rd_dp} = 6'h00;
    {ce, sel_n} = 2'b11;
    {haddr, hwdata, d0, d1} = '0;
    {htrans, gap, m0, m1, baddr, mode} = '0;
    hsize = 3'h2;
    // The array clears on reset, so the shadow starts cleared as well
    foreach (shadow[k]) begin
      shadow[k] = 36'h0_0000_0000;
    end
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(off_ctrl, 32'(`SQW_CTRL_RESET), 32'h0000_000F, "ctrl_rst");
    chk(off_st, 32'h0000_0001 << `SQW_ST_EMPTY_BIT, 32'h0000_FFFF,
        "status_rst");
    wr32(32'h0000_0040, 32'hFFFF_FFFF);
    chk(32'h0000_0040, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    ce <= 1'b0;
    @(posedge hclk);
    #1 check1("stall", 1'b0, hreadyout);
    check1("hresp", 1'b0, hresp);
    @(posedge hclk);
    ce <= 1'b1;
    @(posedge hclk);
    cnt = 0;
    for (int i = 0; i < 4; i++) begin
      mode = 2'(i);
      wr32(off_ctrl, {28'h0, mode, 2'b01});
      burst(1'b0, 4'(i), rnd36(), rnd36(), 6'h00, 6'h00);
      burst(1'b0, 4'(i), rnd36(), rnd36(), 6'h2A, 6'h15);
      cnt += 2;
      wait_cnt(cnt);
      rdback(4'(i));
    end
    burst(1'b0, 4'hC, rnd36(), rnd36(), 6'h00, 6'h00);
    burst(1'b1, 4'hC, rnd36(), rnd36(), 6'h00, 6'h00);
    burst(1'b0, 4'hD, rnd36(), rnd36(), 6'h00, 6'h00);
    cnt += 2;
    wait_cnt(cnt);
    rdback(4'hC);
    // Drain held: eight fill the FIFO, one waits, the tenth is lost
    wr32(off_ctrl, 32'h0000_000F);
    for (int j = 0; j < 10; j++) begin
      burst(1'b0, 4'(j), rnd36(), rnd36(), 6'h00, 6'h00);
    end
    repeat (8) @(posedge hclk);
    chk(off_st, 32'h0000_0086, 32'h0000_00F7, "fifo_full");
    check1("write_ready", 1'b0, write_ready);
    wr32(off_st, 32'h0000_0004);
    chk(off_st, 32'h0000_0000, 32'h0000_0004, "ovf_clear");
    wr32(off_ctrl, 32'h0000_000D);
    cnt += 9;
    wait_cnt(cnt);
    chk(off_st, 32'h0000_0001, 32'h0000_00F7, "fifo_empty");
    check1("write_ready", 1'b1, write_ready);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    tally_and_finish();
  end
endmodule : tb_sram_write_port_select_and_mask
